// ===== ddr_separate_io_sram_port.sv
// Summary of operation
// R01 - Load and direction sampled on true-clock rise
// R02 - Write: address, word0 on rise, word1 after
// R03 - Read: word0 on complement rise, word1 next
// R04 - Load high: no operation, outputs released
// R05 - Stopped clock keeps both ports unchanged
// R06 - Burst toggles lowest address bit, ends after two
// R07 - State steps on true clock from load, direction
// R08 - Write both edges; read launched on clock edges
// R09 - Mask0 lane 0-8, mask1 lane 9-17
// R10 - Controller may change masks between words
// R11 - Wide: four lane masks; narrow: two nibble masks
// R12 - Read port width follows organisation
// R13 - Echo clock pair aligned with read data
// R14 - Read outputs released at power-up and writes
// R15 - Controller should park all clocks alike
// R16 - Masks act only in writes; address deselected ignored
// R17 - Read after write returns newest data
// R18 - New burst may start every true-clock rise
`default_nettype none

module ddr_separate_io_sram_port (
    input  wire logic                              sys_clk,
    input  wire logic                              rst_b,
    input  wire logic                              link_clk,
    input  wire logic                              load_strobe_n,
    input  wire logic                              rw_select,
    input  wire logic [sram_port_pkg::ROW_W-1:0]   word_addr,
    input  wire logic                              burst_lsb,
    input  wire logic                              lane_mask0_n,
    input  wire logic                              lane_mask1_n,
    input  wire logic                              lane_mask2_n,
    input  wire logic                              lane_mask3_n,
    input  wire logic                              half_byte_mask0_n,
    input  wire logic                              half_byte_mask1_n,
    input  wire logic [sram_port_pkg::DATA_W-1:0]  wr_data,
    output logic      [sram_port_pkg::DATA_W-1:0]  rd_data,
    output logic                                   rd_data_oe,
    output logic                                   echo_clk_true,
    output logic                                   echo_clk_comp
);
    import sram_port_pkg::*;

    // Core domain: power-up hold
    logic [PU_CNT_W-1:0]   pu_cnt_q;
    logic [PU_CNT_W-1:0]   pu_cnt_d;
    logic                  pu_done;
    logic                  core_ready_q;

    // Link domain
    logic                  ready_meta_q;
    logic                  ready_q;
    bus_state_t            state_q;
    bus_state_t            state_d;
    logic [MASK_W-1:0]     mask_wide_n;
    logic [MASK_W-1:0]     mask_narrow_n;
    logic [MASK_W-1:0]     mask_sel_n;
    logic [LANES-1:0]      lane_we_in;
    logic                  cmd_load;
    logic                  cmd_rd;
    logic                  cmd_wr;
    logic                  wr_room;
    logic                  in_write;
    logic                  in_read;
    logic [ROW_W-1:0]      row_q;
    logic                  lsb_q;
    logic [DATA_W-1:0]     w0_q;
    logic [LANES-1:0]      m0_q;
    logic [DATA_W-1:0]     w1_q;
    logic [LANES-1:0]      m1_q;

    // Write buffer and array
    logic [ENTRY_W-1:0]    push_entry;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic [ENTRY_W-1:0]    head_entry;
    logic [FIFO_LVL_W-1:0] fifo_level;
    logic                  drain;
    logic [ROW_W-1:0]      head_row;
    logic [ROW_LANES-1:0]  head_we;
    logic [ROW_DATA_W-1:0] head_data;
    logic [ROW_LANES-1:0]  stg_we;
    logic [ROW_DATA_W-1:0] stg_data;
    logic [ROW_DATA_W-1:0] mem_rdata;

    // Forwarding of pending writes into a read
    logic                  stg_hit;
    logic                  head_hit;
    logic [ROW_LANES-1:0]  fwd_we_d;
    logic [ROW_DATA_W-1:0] fwd_data_d;
    logic [ROW_LANES-1:0]  fwd_we_q;
    logic [ROW_DATA_W-1:0] fwd_data_q;
    logic [ROW_DATA_W-1:0] rd_row;
    logic [DATA_W-1:0]     first_word;
    logic [DATA_W-1:0]     second_word;

    // Output stages on both clock edges
    logic                  pos_tog_q;
    logic                  neg_tog_q;
    logic                  phase;
    logic [DATA_W-1:0]     qp_data_q;
    logic                  qp_oe_q;
    logic [DATA_W-1:0]     qn_data_q;
    logic                  qn_oe_q;

    // Core clock: hold the link idle until power-up has elapsed
    assign pu_done  = (pu_cnt_q == PU_CNT_W'(POWERUP_CYC));
    assign pu_cnt_d = pu_done ? pu_cnt_q : pu_cnt_q + 1'b1;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pu_cnt_q <= '0;
        end else begin
            pu_cnt_q <= pu_cnt_d;
        end
    end

    // Ready flag for the link side, cleared again by every reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            core_ready_q <= 1'b0;
        end else begin
            core_ready_q <= pu_done;
        end
    end

    // Ready level crosses into the link domain
    always_ff @(posedge link_clk) begin
        ready_meta_q <= core_ready_q;
        ready_q      <= ready_meta_q;
    end

    // Lane masks per organisation
    assign mask_wide_n   = {lane_mask3_n, lane_mask2_n, lane_mask1_n, lane_mask0_n}; // [R09] [R11]
    assign mask_narrow_n = {2'h3, half_byte_mask1_n, half_byte_mask0_n}; // [R11]
    assign mask_sel_n    = (ORG_W == 8) ? mask_narrow_n : mask_wide_n;
    assign lane_we_in    = ~mask_sel_n[LANES-1:0]; // [R09]

    // Command decode at the true-clock rise
    assign wr_room  = fifo_in_ready && (fifo_level <= FIFO_LVL_W'(FIFO_ROOM));
    assign cmd_load = ready_q & ~load_strobe_n; // [R01] [R04]
    assign cmd_rd   = cmd_load & rw_select; // [R03] [R07]
    assign cmd_wr   = cmd_load & ~rw_select & wr_room; // [R02] [R07]
    assign in_write = (state_q == ST_WRITE);
    assign in_read  = (state_q == ST_READ);

    // Next bus cycle from load strobe and direction
    always_comb begin
        unique case ({cmd_rd, cmd_wr})
            2'h2:    state_d = ST_READ;
            2'h1:    state_d = ST_WRITE;
            default: state_d = ST_IDLE; // [R04]
        endcase
    end

    // True-clock rise: step the bus cycle
    always_ff @(posedge link_clk) begin
        if (!ready_q) begin
            state_q <= ST_IDLE; // [R14]
        end else begin
            state_q <= state_d; // [R07] [R18]
        end
    end

    // Address and burst order are held only when a burst is loaded
    always_ff @(posedge link_clk) begin
        if (!ready_q) begin
            row_q <= '0;
            lsb_q <= 1'b0;
        end else if (cmd_rd || cmd_wr) begin
            row_q <= word_addr; // [R16]
            lsb_q <= burst_lsb;
        end
    end

    // First write word; its lanes are enabled only by a taken write
    always_ff @(posedge link_clk) begin
        if (!ready_q) begin
            w0_q <= '0;
            m0_q <= '0;
        end else begin
            w0_q <= wr_data; // [R08]
            m0_q <= cmd_wr ? lane_we_in : '0; // [R02] [R16]
        end
    end

    // Complement-clock rise: second write word
    always_ff @(negedge link_clk) begin
        if (!ready_q) begin
            w1_q <= '0;
        end else begin
            w1_q <= wr_data; // [R02] [R08]
        end
    end

    // Mask of the second word, sampled apart from the first
    always_ff @(negedge link_clk) begin
        if (!ready_q) begin
            m1_q <= '0;
        end else begin
            m1_q <= in_write ? lane_we_in : '0; // [R09] [R10] [R16]
        end
    end

    // Completed burst; the second word goes to the other half of the pair
    assign stg_data   = lsb_q ? {w0_q, w1_q} : {w1_q, w0_q}; // [R06]
    assign stg_we     = lsb_q ? {m0_q, m1_q} : {m1_q, m0_q}; // [R06]
    assign push_entry = {row_q, stg_we, stg_data};

    sync_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (link_clk),
        .clr_b     (ready_q),
        .in_valid  (in_write),
        .in_ready  (fifo_in_ready),
        .in_data   (push_entry),
        .out_valid (fifo_out_valid),
        .out_ready (ready_q),
        .out_data  (head_entry),
        .level     (fifo_level)
    );

    // The array commits one buffered burst per link cycle
    assign drain     = fifo_out_valid & ready_q;
    assign head_row  = head_entry[ENTRY_ROW_LSB +: ROW_W];
    assign head_we   = head_entry[ENTRY_WE_LSB +: ROW_LANES];
    assign head_data = head_entry[ENTRY_DATA_LSB +: ROW_DATA_W];

    sram_row_mem #(
        .ROW_W   (ROW_W),
        .LANE_W  (LANE_W),
        .LANES_N (ROW_LANES)
    ) u_array (
        .clk     (link_clk),
        .wr_en   (drain),
        .wr_row  (head_row),
        .wr_lane (head_we),
        .wr_data (head_data),
        .rd_en   (cmd_rd),
        .rd_row  (word_addr),
        .rd_data (mem_rdata)
    );

    // Lanes still in flight win over the array; the newer burst wins over the head
    assign stg_hit  = in_write && (row_q == word_addr); // [R17]
    assign head_hit = drain && (head_row == word_addr); // [R17]

    for (genvar k = 0; k < ROW_LANES; k++) begin : g_fwd
        logic stg_lane;
        assign stg_lane    = stg_hit & stg_we[k];
        assign fwd_we_d[k] = stg_lane | (head_hit & head_we[k]); // [R17]
        assign fwd_data_d[k*LANE_W +: LANE_W] = stg_lane ? stg_data[k*LANE_W +: LANE_W]
                                                         : head_data[k*LANE_W +: LANE_W];
        assign rd_row[k*LANE_W +: LANE_W] = fwd_we_q[k] ? fwd_data_q[k*LANE_W +: LANE_W]
                                                        : mem_rdata[k*LANE_W +: LANE_W];
    end

    // Lanes taken from pending writes, chosen at the read's true-clock rise
    always_ff @(posedge link_clk) begin
        if (!ready_q) begin
            fwd_we_q <= '0;
        end else if (cmd_rd) begin
            fwd_we_q <= fwd_we_d; // [R17]
        end
    end

    // Pending data for those lanes
    always_ff @(posedge link_clk) begin
        if (!ready_q) begin
            fwd_data_q <= '0;
        end else if (cmd_rd) begin
            fwd_data_q <= fwd_data_d; // [R17]
        end
    end

    // Burst order: addressed word first, lowest address bit toggled second
    assign first_word  = lsb_q ? rd_row[DATA_W +: DATA_W] : rd_row[0 +: DATA_W]; // [R06]
    assign second_word = lsb_q ? rd_row[0 +: DATA_W] : rd_row[DATA_W +: DATA_W]; // [R06]

    // Echo toggle on every true-clock rise, whatever the bus does
    always_ff @(posedge link_clk) begin
        if (!ready_q) begin
            pos_tog_q <= 1'b0;
        end else begin
            pos_tog_q <= ~pos_tog_q; // [R13]
        end
    end

    // Second read word launched on the true-clock rise after the command
    always_ff @(posedge link_clk) begin
        if (!ready_q) begin
            qp_data_q <= '0;
        end else begin
            qp_data_q <= second_word; // [R03] [R08]
        end
    end

    // Drive enable for the second half of the period
    always_ff @(posedge link_clk) begin
        if (!ready_q) begin
            qp_oe_q <= 1'b0; // [R14]
        end else begin
            qp_oe_q <= in_read; // [R04] [R14]
        end
    end

    // Echo follows the true clock into the complement half
    always_ff @(negedge link_clk) begin
        if (!ready_q) begin
            neg_tog_q <= 1'b0;
        end else begin
            neg_tog_q <= pos_tog_q; // [R13]
        end
    end

    // First read word launched on the complement-clock rise
    always_ff @(negedge link_clk) begin
        if (!ready_q) begin
            qn_data_q <= '0;
        end else begin
            qn_data_q <= first_word; // [R03] [R08]
        end
    end

    // Drive enable for the first half of the period
    always_ff @(negedge link_clk) begin
        if (!ready_q) begin
            qn_oe_q <= 1'b0; // [R14]
        end else begin
            qn_oe_q <= in_read; // [R04] [R14]
        end
    end

    // Phase is high after a true-clock rise, low after a complement rise;
    // with the clock stopped every stage keeps its value
    assign phase         = pos_tog_q ^ neg_tog_q; // [R05]
    assign rd_data       = phase ? qp_data_q : qn_data_q; // [R08] [R12]
    assign rd_data_oe    = phase ? qp_oe_q : qn_oe_q; // [R14]
    assign echo_clk_true = phase; // [R13]
    assign echo_clk_comp = ~phase; // [R13]

endmodule : ddr_separate_io_sram_port

`default_nettype wire

// ===== sram_ctl_model.sv
`default_nettype none

module sram_ctl_model (
    input  wire logic                             link_clk,
    output logic                                  load_strobe_n,
    output logic                                  rw_select,
    output logic      [sram_port_pkg::ROW_W-1:0]  word_addr,
    output logic                                  burst_lsb,
    output logic      [sram_port_pkg::MASK_W-1:0] mask_n,
    output logic      [sram_port_pkg::DATA_W-1:0] wr_data,
    input  wire logic [sram_port_pkg::DATA_W-1:0] rd_data,
    input  wire logic                             rd_data_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    import sram_port_pkg::*;
    logic [DATA_W-1:0] got[$];
    initial begin
        load_strobe_n = 1'b1;
        rw_select     = 1'b0;
        word_addr     = '0;
        burst_lsb     = 1'b0;
        mask_n        = '1;
        wr_data       = '0;
    end
    // Read words taken mid-way through their half period
    always @(link_clk) begin
        #12;
        if (rd_data_oe === 1'b1)
            got.push_back(rd_data);
    end
    // Control valid around the rise, second word around the fall
    task automatic op(input logic rd, input logic [ROW_W-1:0] a, input logic lsb,
                      input logic [MASK_W-1:0] m0, m1, input logic [DATA_W-1:0] d0, d1);
        @(negedge link_clk);
        load_strobe_n <= 1'b0;
        rw_select     <= rd;
        word_addr     <= a;
        burst_lsb     <= lsb;
        mask_n        <= m0;
        wr_data       <= d0;
        @(posedge link_clk);
        load_strobe_n <= 1'b1;
        rw_select     <= ~rd;
        word_addr     <= ~a;
        burst_lsb     <= ~lsb;
        mask_n        <= m1;
        wr_data       <= d1;
    endtask : op
    task automatic idle(input logic [DATA_W-1:0] d);
        @(negedge link_clk);
        load_strobe_n <= 1'b1;
        rw_select     <= 1'b0;
        word_addr     <= d[ROW_W-1:0];
        mask_n        <= '0;
        wr_data       <= d;
    endtask : idle
endmodule : sram_ctl_model

`default_nettype wire

// ===== sram_port_monitor.sv
`default_nettype none

module sram_port_monitor (
    input wire logic                             sys_clk,
    input wire logic                             rst_b,
    input wire logic                             link_clk,
    input wire logic                             load_strobe_n,
    input wire logic                             rw_select,
    input wire logic [sram_port_pkg::DATA_W-1:0] rd_data,
    input wire logic                             rd_data_oe,
    input wire logic                             echo_clk_true,
    input wire logic                             echo_clk_comp
);
    timeunit 1ns;
    timeprecision 100ps;
    import sram_port_pkg::*;
    logic       rdy_q;
    logic       rd_q;
    logic       wr_q;
    logic       pos_t_q = 1'b0;
    logic       neg_t_q = 1'b0;
    logic [1:0] sig_q;
    logic [1:0] still_q;
    logic [1:0] still_d;
    // Counts core cycles without any link clock edge
    assign still_d = ({pos_t_q, neg_t_q} != sig_q) ? 2'h0 : still_q + {1'h0, still_q != 2'h3};
    always_ff @(negedge link_clk) begin
        rdy_q   <= echo_clk_true;
        neg_t_q <= !neg_t_q;
    end
    always_ff @(posedge link_clk) begin
        rd_q    <= !load_strobe_n && rw_select && rdy_q;
        wr_q    <= !load_strobe_n && !rw_select;
        pos_t_q <= !pos_t_q;
    end
    always_ff @(posedge sys_clk) begin
        sig_q   <= {pos_t_q, neg_t_q};
        still_q <= still_d;
    end
    a_echo_inverse: assert property (@(posedge link_clk) disable iff (!rst_b)
        echo_clk_comp == !echo_clk_true) else $error("echo pair not complementary");
    a_echo_rise_low: assert property (@(posedge link_clk) disable iff (!rst_b)
        !echo_clk_true) else $error("echo high before link rise");
    a_echo_keeps: assert property (@(negedge link_clk) disable iff (!rst_b)
        echo_clk_true |=> echo_clk_true) else $error("echo stopped toggling");
    a_nop_quiet: assert property (@(posedge link_clk) disable iff (!rst_b)
        load_strobe_n |=> !rd_data_oe) else $error("read port driven after no-op");
    a_read_first: assert property (@(posedge link_clk) disable iff (!rst_b)
        !load_strobe_n && rw_select && rdy_q |=> rd_data_oe) else $error("first word missing");
    a_read_second: assert property (@(negedge link_clk) disable iff (!rst_b)
        rd_q |=> rd_data_oe) else $error("second word missing");
    a_write_quiet: assert property (@(negedge link_clk) disable iff (!rst_b)
        wr_q |=> !rd_data_oe) else $error("read port driven in write");
    a_stop_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        still_q == 2'h3 && {pos_t_q, neg_t_q} == sig_q |->
        $stable(rd_data) && $stable(rd_data_oe) && $stable(echo_clk_true))
        else $error("outputs moved while link clock stopped");
endmodule : sram_port_monitor

bind ddr_separate_io_sram_port sram_port_monitor sram_port_monitor_i (
    .sys_clk, .rst_b, .link_clk, .load_strobe_n, .rw_select, .rd_data, .rd_data_oe,
    .echo_clk_true, .echo_clk_comp
);

`default_nettype wire

// ===== sram_port_pkg.sv
`default_nettype none

package sram_port_pkg;

    // Organisation: 8, 18 or 36 data bits
    localparam int ORG_W          = 36;
    localparam int DATA_W         = ORG_W;
    localparam int LANE_W         = (ORG_W == 8) ? 4 : 9;
    localparam int LANES          = ORG_W / LANE_W;
    localparam int MASK_W         = 4;
    localparam int ADDR_W         = (ORG_W == 8) ? 21 : ((ORG_W == 18) ? 20 : 19);
    localparam int ROW_W          = ADDR_W - 1;

    // One memory row holds both words of a burst pair
    localparam int ROW_LANES      = 2 * LANES;
    localparam int ROW_DATA_W     = 2 * DATA_W;
    localparam int ENTRY_W        = ROW_W + ROW_LANES + ROW_DATA_W;
    localparam int ENTRY_DATA_LSB = 0;
    localparam int ENTRY_WE_LSB   = ROW_DATA_W;
    localparam int ENTRY_ROW_LSB  = ROW_DATA_W + ROW_LANES;

    // Write buffer between the link and the array
    localparam int FIFO_DEPTH     = 16;
    localparam int FIFO_LVL_W     = $clog2(FIFO_DEPTH) + 1;
    localparam int FIFO_ROOM      = FIFO_DEPTH - 2;

    // Power-up hold on the core clock
    localparam int SYS_CLK_PS     = 25000;
    localparam int POWERUP_NS     = 1000;
    localparam int POWERUP_CYC    = (POWERUP_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
    localparam int PU_CNT_W       = $clog2(POWERUP_CYC + 1);

    // Bus cycle in flight during the current link clock period
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_READ  = 2'h1,
        ST_WRITE = 2'h2
    } bus_state_t;

endpackage : sram_port_pkg

`default_nettype wire

// ===== sram_row_mem.sv
`default_nettype none

module sram_row_mem #(
    parameter int ROW_W   = 18,
    parameter int LANE_W  = 9,
    parameter int LANES_N = 8
) (
    input  wire logic                       clk,
    input  wire logic                       wr_en,
    input  wire logic [ROW_W-1:0]           wr_row,
    input  wire logic [LANES_N-1:0]         wr_lane,
    input  wire logic [LANES_N*LANE_W-1:0]  wr_data,
    input  wire logic                       rd_en,
    input  wire logic [ROW_W-1:0]           rd_row,
    output logic      [LANES_N*LANE_W-1:0]  rd_data
);

    // One array per lane; a read in the cycle of a write returns the old data
    for (genvar k = 0; k < LANES_N; k++) begin : g_lane
        logic [LANE_W-1:0] cell_q [2**ROW_W];
        logic [LANE_W-1:0] rd_q;

        always_ff @(posedge clk) begin
            if (wr_en && wr_lane[k]) begin
                cell_q[wr_row] <= wr_data[k*LANE_W +: LANE_W];
            end
            if (rd_en) begin
                rd_q <= cell_q[rd_row];
            end
        end

        assign rd_data[k*LANE_W +: LANE_W] = rd_q;
    end

endmodule : sram_row_mem

`default_nettype wire

// ===== sync_fifo.sv
`default_nettype none

module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk,
    input  wire logic                       clr_b,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic      [WIDTH-1:0]           out_data,
    output logic      [$clog2(DEPTH):0]     level
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign in_ready  = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = buf_q[rd_ptr_q];
    assign level     = count_q;
    assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (!clr_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
            count_q  <= count_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            buf_q[wr_ptr_q] <= in_data;
        end
    end

endmodule : sync_fifo

`default_nettype wire

// ===== tb_ddr_separate_io_sram_port.sv
`default_nettype none

module tb_ddr_separate_io_sram_port;
    timeunit 1ns;
    timeprecision 100ps;
    import sram_port_pkg::*;
    logic              sys_clk;
    logic              rst_b;
    logic              link_clk;
    logic              link_run;
    logic              load_strobe_n;
    logic              rw_select;
    logic [ROW_W-1:0]  word_addr;
    logic              burst_lsb;
    logic [MASK_W-1:0] mask_n;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rd_data;
    logic              rd_data_oe;
    logic              echo_clk_true;
    logic              echo_clk_comp;
    logic [DATA_W-1:0] shadow[logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] exp_q[$];
    int                err_total = 0;
    int                n_tests = 0;
    int                cyc = 0;

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever begin
            #24;
            if (link_run)
                link_clk = ~link_clk;
        end
    end

    ddr_separate_io_sram_port ddr_separate_io_sram_port_i (
        .sys_clk, .rst_b, .link_clk, .load_strobe_n, .rw_select, .word_addr, .burst_lsb,
        .lane_mask0_n(mask_n[0]), .lane_mask1_n(mask_n[1]), .lane_mask2_n(mask_n[2]),
        .lane_mask3_n(mask_n[3]), .half_byte_mask0_n(mask_n[0]),
        .half_byte_mask1_n(mask_n[1]), .wr_data, .rd_data, .rd_data_oe, .echo_clk_true,
        .echo_clk_comp
    );
    sram_ctl_model sram_ctl_model_i (
        .link_clk, .load_strobe_n, .rw_select, .word_addr, .burst_lsb, .mask_n, .wr_data,
        .rd_data, .rd_data_oe
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [DATA_W-1:0] old(input logic [ADDR_W-1:0] k);
        return shadow.exists(k) ? shadow[k] : 'x;
    endfunction : old
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
                                                input logic [MASK_W-1:0] m);
        for (int i = 0; i < LANES; i++) begin
            if (!m[i])
                o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
        end
        return o;
    endfunction : merge
    task automatic wr(input logic [ROW_W-1:0] a, input logic b, input logic [MASK_W-1:0] m0,
                      m1, input logic [DATA_W-1:0] d0, d1);
        sram_ctl_model_i.op(1'b0, a, b, m0, m1, d0, d1);
        shadow[{a, b}]  = merge(old({a, b}), d0, m0);
        shadow[{a, !b}] = merge(old({a, !b}), d1, m1);
    endtask : wr
    task automatic rd(input logic [ROW_W-1:0] a, input logic b);
        sram_ctl_model_i.op(1'b1, a, b, 4'h0, 4'h0, ~wr_data, wr_data);
        exp_q.push_back(old({a, b}));
        exp_q.push_back(old({a, !b}));
    endtask : rd
    task automatic drain();
        repeat (4) @(posedge link_clk);
        check("read count", DATA_W'(sram_ctl_model_i.got.size()), DATA_W'(exp_q.size()));
        while (exp_q.size() != 0 && sram_ctl_model_i.got.size() != 0)
            check("read word", sram_ctl_model_i.got.pop_front(), exp_q.pop_front());
        exp_q.delete();
        sram_ctl_model_i.got.delete();
    endtask : drain

    task automatic t_reset();
        repeat (8) @(posedge sys_clk);
        check("oe in reset", DATA_W'(rd_data_oe), '0);
        rst_b <= 1'b1;
        repeat (20) @(posedge sys_clk);
        check("oe in power-up", DATA_W'(rd_data_oe), '0);
        check("echo in power-up", DATA_W'(echo_clk_comp), DATA_W'(1'b1));
        repeat (60) @(posedge sys_clk);
    endtask : t_reset
    task automatic t_burst();
        wr(18'h1_2345, 1'b1, 4'h0, 4'h0, 36'h1_2345_6789, 36'hF_EDCB_A987);
        rd(18'h1_2345, 1'b1);
        rd(18'h1_2345, 1'b0);
        drain();
    endtask : t_burst
    task automatic t_masks();
        wr(18'h0_0A5A, 1'b0, 4'h0, 4'h0, 36'h0, 36'hF_FFFF_FFFF);
        for (int i = 0; i < LANES; i++) begin
            wr(18'h0_0A5A, 1'b0, ~(4'h1 << i), ~(4'h8 >> i), 36'h5_A5A5_A5A5 + DATA_W'(i),
               36'hA_5A5A_5A5A - DATA_W'(i));
            rd(18'h0_0A5A, 1'b0);
        end
        wr(18'h0_0A5A, 1'b0, 4'hF, 4'hF, 36'h3_3333_3333, 36'hC_CCCC_CCCC);
        rd(18'h0_0A5A, 1'b1);
        drain();
    endtask : t_masks
    task automatic t_nop();
        for (int i = 0; i < 6; i++)
            sram_ctl_model_i.idle(36'h9_6969_2345 ^ (DATA_W'(i) << 20));
        drain();
        rd(18'h1_2345, 1'b0);
        drain();
    endtask : t_nop
    task automatic t_stop();
        rd(18'h0_0A5A, 1'b0);
        @(posedge sys_clk);
        link_run <= 1'b0;
        repeat (20) @(posedge sys_clk);
        link_run <= 1'b1;
        rd(18'h1_2345, 1'b1);
        drain();
    endtask : t_stop

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        rst_b    = 1'b0;
        link_run = 1'b1;
        t_reset();
        t_burst();
        t_masks();
        t_nop();
        t_stop();
        conclude();
    end
endmodule : tb_ddr_separate_io_sram_port

`default_nettype wire
